// [pio_ext_mem.sv]
// Purpose: behavioural external memory on the expansion bus
// Assumes: sees resolved pin levels
// Notes: stalls a set number of bus clock falls with wait
`timescale 1ns/1ps
module pio_ext_mem
   import pio_pkg::*;
(
   input wire logic [31:0] i_pin,
   input wire logic [7:0] i_wait_cnt,
   output logic [7:0] o_data,
   output logic o_data_en,
   output logic o_wait_n
);
   // ---------------------------------
   // store and stall
   // ---------------------------------
   logic [7:0] mem [256]; // indexed by low address byte
   logic [7:0] left = 8'h00; // stall steps still to go
   wire logic strb_n = i_pin[24+D_STRB];
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = i[7:0] ^ 8'h5a;
      end
   end
   assign o_data_en = !strb_n && i_pin[24+D_RW];
   assign o_data = mem[i_pin[15:8]];
   // last value seen while strobe is low wins
   always @(i_pin) begin
      // read the strobe from the same vector so that its edge and the data agree
      if (!i_pin[24+D_STRB] && !i_pin[24+D_RW]) mem[i_pin[15:8]] = i_pin[7:0];
   end
   always @(negedge strb_n) left = i_wait_cnt;
   always @(negedge i_pin[24+D_BCLK]) begin
      if (!strb_n && left != 8'h00) left = left - 8'h01;
   end
   assign o_wait_n = (left == 8'h00);
endmodule // pio_ext_mem

// [pio_pkg.sv]
// Purpose: constants and types for the port pin function and expansion bus block
// Assumes: core clock is the oscillator clock; register frame at 1020h-102Fh
// Notes: one frame word per register, four registers per port
package pio_pkg;
   // ----------------------------------------------------------------
   // register frame
   // ----------------------------------------------------------------
   localparam logic [15:0] FRAME_BASE = 16'h1020;
   localparam logic [15:0] FRAME_LAST = 16'h102f;
   localparam logic [1:0] REG_SEL1 = 2'h0;
   localparam logic [1:0] REG_SEL2 = 2'h1;
   localparam logic [1:0] REG_DATA = 2'h2;
   localparam logic [1:0] REG_DIR = 2'h3;
   localparam logic [7:0] RST_SEL = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] BUS_SEL = 8'hff;
   localparam int NPORT = 4;
   localparam int PORT_MAX = 8;
   // port indices
   localparam int PA = 0;
   localparam int PB = 1;
   localparam int PC = 2;
   localparam int PD = 3;
   // port d control pin positions
   localparam int D_WAIT = 2;
   localparam int D_BANK = 3;
   localparam int D_RW = 4;
   localparam int D_FETCH = 5;
   localparam int D_BCLK = 6;
   localparam int D_STRB = 7;
   // bus clock divide ratio against the oscillator
   localparam int BUS_CLK_DIV = 4;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] sel1;
      logic [7:0] sel2;
      logic [7:0] data;
      logic [7:0] dir;
   } pio_port_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ADDR = 4'b0010,
      ST_STRB = 4'b0100,
      ST_DONE = 4'b1000
   } pio_state_t;
endpackage

// [pio_port.sv]
// Purpose: port registers, pin muxing and nonmultiplexed expansion bus
// Assumes: core requests are on i_clk_sys; pins are asynchronous
// Notes: pin i_pin_in[8*p+b] is port p bit b, port a is p=0
`timescale 1ns/1ps
module pio_port
   import pio_pkg::*;
#(
   parameter int PORT_B_W = 8,
   parameter int PORT_C_W = 8,
   parameter int PORT_D_W = 8,
   parameter int CLK_DIV = BUS_CLK_DIV
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_mode_select_pin,
   input wire logic i_prog_mem_dis,
   input wire logic i_acc_req,
   input wire logic [15:0] i_acc_addr,
   input wire logic i_acc_wr,
   input wire logic i_acc_fetch,
   input wire logic i_acc_ext,
   input wire logic [7:0] i_acc_wdata,
   output logic o_acc_ready,
   output logic o_acc_done,
   output logic [7:0] o_acc_rdata,
   input wire logic [31:0] i_pin_in,
   output logic [31:0] o_pin_out,
   output logic [31:0] o_pin_oe_n
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // port width limit
   if (PORT_B_W > PORT_MAX || PORT_C_W > PORT_MAX || PORT_D_W > PORT_MAX ||
       PORT_B_W < 0 || PORT_C_W < 0 || PORT_D_W < 0) begin : g_bad_width
      $error("port width out of range");
   end
   // divider counter is four bits and splits the period in two halves
   if (CLK_DIV < 2 || CLK_DIV > 16 || (CLK_DIV % 2) != 0) begin : g_bad_div
      $error("bus clock divider must be even, 2 to 16");
   end

   // mask of implemented pins for a width
   function automatic logic [7:0] width_mask(input int w);
      logic [8:0] m;
      m = (9'h001 << w) - 9'h001;
      return m[7:0];
   endfunction

   localparam logic [31:0] PIN_MASK = {width_mask(PORT_D_W), width_mask(PORT_C_W),
                                       width_mask(PORT_B_W), 8'hff};

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   pio_port_t port [NPORT]; // per port control, data, direction
   logic [31:0] pin_s1; // first sync stage, read only by pin_s2
   logic [31:0] pin_s2; // synchronised pin levels
   logic mode_s1; // strap sync stages
   logic mode_s2;
   logic [1:0] init_cnt; // delay until strap sync is settled
   logic init_done; // ports configured from strap
   logic [3:0] div_cnt; // bus clock phase
   logic bclk; // bus clock level
   logic bclk_rise; // one cycle before bus clock rises
   pio_state_t state;
   logic [15:0] bus_addr; // held address of current cycle
   logic [7:0] bus_wdata; // held write data
   logic bus_wr; // current cycle writes
   logic bus_fetch; // current cycle is opcode fetch
   logic rw_lvl; // read/write line level
   logic strb_n; // strobe, active low
   logic in_frame;
   logic go_ext;
   logic go_int;
   logic [31:0] fn_out; // expansion function drive
   logic [31:0] fn_oe; // expansion function enable, active high

   // ----------------------------------------------------------------
   // pin and strap synchronisers
   // ----------------------------------------------------------------
   // two stages; only stage two feeds logic
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_s1 <= 32'h0000_0000;
         pin_s2 <= 32'h0000_0000;
         mode_s1 <= 1'b0;
         mode_s2 <= 1'b0;
      end else if (i_ce) begin
         pin_s1 <= i_pin_in;
         pin_s2 <= pin_s1;
         mode_s1 <= i_mode_select_pin;
         mode_s2 <= mode_s1;
      end
   end

   // ----------------------------------------------------------------
   // bus clock divider
   // ----------------------------------------------------------------
   // bus clock at core rate over CLK_DIV, a quarter at the default
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         div_cnt <= 4'h0;
         bclk <= 1'b0;
      end else if (i_ce) begin
         div_cnt <= bclk_rise ? 4'h0 : div_cnt + 4'h1;
         bclk <= bclk_rise ? 1'b1 : (div_cnt == 4'((CLK_DIV / 2) - 1)) ? 1'b0 : bclk;
      end
   end
   assign bclk_rise = (div_cnt == 4'(CLK_DIV - 1));

   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   assign in_frame = (i_acc_addr >= FRAME_BASE) && (i_acc_addr <= FRAME_LAST);
   assign o_acc_ready = init_done && (state == ST_IDLE);
   assign go_ext = o_acc_ready && i_acc_req && (i_acc_ext || (in_frame && i_prog_mem_dis));
   assign go_int = o_acc_ready && i_acc_req && !go_ext;

   // ----------------------------------------------------------------
   // port registers
   // ----------------------------------------------------------------
   // strap applied after sync settles; core writes to the frame after
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         init_cnt <= 2'h0;
         init_done <= 1'b0;
         for (int p = 0; p < NPORT; p++) begin
            port[p] <= '{sel1: RST_SEL, sel2: RST_SEL, data: RST_DATA, dir: RST_DIR};
         end
      end else if (i_ce) begin
         if (!init_done) begin
            init_cnt <= init_cnt + 2'h1;
            if (init_cnt == 2'h3) begin
               init_done <= 1'b1;
               if (mode_s2) begin
                  port[PA].sel1 <= BUS_SEL;
                  port[PB].sel1 <= BUS_SEL;
                  port[PC].sel1 <= BUS_SEL;
               end
            end
         end else if (go_int && in_frame && i_acc_wr) begin
            case (i_acc_addr[1:0])
               REG_SEL1: port[i_acc_addr[3:2]].sel1 <= i_acc_wdata;
               REG_SEL2: port[i_acc_addr[3:2]].sel2 <= i_acc_wdata;
               REG_DATA: port[i_acc_addr[3:2]].data <= i_acc_wdata;
               REG_DIR: port[i_acc_addr[3:2]].dir <= i_acc_wdata;
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // expansion bus sequencer
   // ----------------------------------------------------------------
   // external cycles step on bus clock rises so that peripherals can
   // follow them; internal accesses finish in one core cycle
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= ST_IDLE;
         strb_n <= 1'b1;
      end else if (i_ce) begin
         case (state)
            ST_IDLE: begin
               if (go_ext) begin
                  state <= ST_ADDR;
               end else if (go_int) begin
                  state <= ST_DONE;
               end
            end
            ST_ADDR: begin
               // strobe low for the operation only
               if (bclk_rise) begin
                  state <= ST_STRB;
                  strb_n <= 1'b0;
               end
            end
            ST_STRB: begin
               // wait sampled at rise after strobe
               // low wait holds the bus a cycle more
               if (bclk_rise && pin_s2[8 * PD + D_WAIT]) begin
                  state <= ST_DONE;
                  strb_n <= 1'b1;
               end
            end
            ST_DONE: state <= ST_IDLE;
            default: begin
               state <= ST_IDLE;
               strb_n <= 1'b1;
            end
         endcase
      end
   end

   // held address, data and cycle type
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         bus_addr <= 16'h0000;
         bus_wdata <= 8'h00;
         bus_wr <= 1'b0;
         bus_fetch <= 1'b0;
      end else if (i_ce) begin
         if (go_ext || go_int) begin
            bus_addr <= i_acc_addr;
            bus_wdata <= i_acc_wdata;
            bus_wr <= i_acc_wr;
            bus_fetch <= i_acc_fetch && !i_acc_wr;
         end else if (state == ST_DONE) begin
            bus_fetch <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rw_lvl <= 1'b1;
      end else if (i_ce) begin
         if (go_ext || go_int) begin
            rw_lvl <= !i_acc_wr;
         end else if (state == ST_DONE) begin
            rw_lvl <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // read data and completion
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_acc_rdata <= 8'h00;
         o_acc_done <= 1'b0;
      end else if (i_ce) begin
         o_acc_done <= 1'b0;
         if (go_int) begin
            o_acc_done <= 1'b1;
            o_acc_rdata <= 8'h00;
            if (in_frame && !i_acc_wr) begin
               case (i_acc_addr[1:0])
                  REG_SEL1: o_acc_rdata <= port[i_acc_addr[3:2]].sel1;
                  REG_SEL2: o_acc_rdata <= port[i_acc_addr[3:2]].sel2;
                  REG_DATA: o_acc_rdata <= pin_s2[8 * i_acc_addr[3:2] +: 8] &
                                           PIN_MASK[8 * i_acc_addr[3:2] +: 8];
                  REG_DIR: o_acc_rdata <= port[i_acc_addr[3:2]].dir;
                  default: o_acc_rdata <= 8'h00;
               endcase
            end
         end else if (state == ST_STRB && bclk_rise && pin_s2[8 * PD + D_WAIT]) begin
            // read data taken as strobe rises
            o_acc_done <= 1'b1;
            o_acc_rdata <= bus_wr ? 8'h00 : pin_s2[8 * PA +: 8];
         end
      end
   end

   // ----------------------------------------------------------------
   // expansion function drive per port
   // ----------------------------------------------------------------
   always_comb begin
      fn_out = 32'h0000_0000;
      fn_oe = 32'h0000_0000;
      // write data driven after strobe falls
      fn_out[8 * PA +: 8] = bus_wdata;
      fn_oe[8 * PA +: 8] = {8{bus_wr && !strb_n}};
      fn_out[8 * PB +: 8] = bus_addr[7:0];
      fn_oe[8 * PB +: 8] = 8'hff;
      fn_out[8 * PC +: 8] = bus_addr[15:8];
      fn_oe[8 * PC +: 8] = 8'hff;
      fn_out[8 * PD + D_BANK] = strb_n || !bus_addr[15];
      fn_out[8 * PD + D_RW] = rw_lvl;
      // fetch marker low during opcode fetch
      fn_out[8 * PD + D_FETCH] = !(bus_fetch && state != ST_IDLE);
      fn_out[8 * PD + D_BCLK] = bclk;
      fn_out[8 * PD + D_STRB] = strb_n;
      fn_oe[8 * PD +: 8] = 8'hff;
      fn_oe[8 * PD + D_WAIT] = 1'b0;
   end

   // ----------------------------------------------------------------
   // pin multiplexer
   // ----------------------------------------------------------------
   // every port pin is programmable
   // unimplemented pins are never driven
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         for (int b = 0; b < PORT_MAX; b++) begin
            // either select bit picks the function
            if (port[p].sel1[b] || port[p].sel2[b]) begin
               // bus function ignores data and direction
               o_pin_out[8 * p + b] = fn_out[8 * p + b];
               o_pin_oe_n[8 * p + b] = !(fn_oe[8 * p + b] && PIN_MASK[8 * p + b]);
            end else begin
               // high output on bank pin keeps bank off
               o_pin_out[8 * p + b] = port[p].data[b];
               o_pin_oe_n[8 * p + b] = !(port[p].dir[b] && PIN_MASK[8 * p + b]);
            end
         end
      end
   end

endmodule // pio_port

// [pio_port_asserts.sv]
// Purpose: concurrent checks on the port pins and expansion bus
// Assumes: CLK_DIV of 4 and i_ce held high
// Notes: port d bus pins are judged only while they drive
`timescale 1ns/1ps
module pio_port_asserts
   import pio_pkg::*;
#(
   parameter int CLK_DIV = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_prog_mem_dis,
   input wire logic i_acc_req,
   input wire logic i_acc_wr,
   input wire logic i_acc_fetch,
   input wire logic i_acc_ext,
   input wire logic o_acc_ready,
   input wire logic o_acc_done,
   input wire logic [31:0] i_pin_in,
   input wire logic [31:0] o_pin_out,
   input wire logic [31:0] o_pin_oe_n
);
   // ---------------------------------
   // pin views and sequences
   // ---------------------------------
   localparam int SPAN = 9 * CLK_DIV; // strobe tail allowed with bench stalls
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   wire logic strb_n = o_pin_out[24+D_STRB]; // strobe, active low
   wire logic bclk = o_pin_out[24+D_BCLK];
   wire logic fet_n = o_pin_out[24+D_FETCH]; // fetch marker, active low
   wire logic dfn = (o_pin_oe_n[31:28] == 4'h0); // bus pins of port d drive
   wire logic wt_n = i_pin_in[24+D_WAIT];
   wire logic take = i_ce && o_acc_ready && i_acc_req; // request taken here
   sequence s_bclk_turn;
      bclk ##1 !bclk [*2] ##1 bclk;
   endsequence
   sequence s_strobe_span;
      !strb_n [*4] ##[0:SPAN] strb_n;
   endsequence
   // last low bus clock cycle, strobe low, synced wait seen low
   sequence s_wait_held;
      !bclk && !$past(bclk) && $past(bclk, 2) && !strb_n && dfn && $past(!wt_n, 2);
   endsequence
   chk_internal_done: assert property (take && !i_acc_ext && !i_prog_mem_dis |=> o_acc_done)
      else $error("internal access not answered next cycle");
   chk_strobe_busy: assert property (!strb_n && dfn |-> !o_acc_ready)
      else $error("strobe low while idle");
   chk_bank_upper: assert property (!o_pin_out[27] && !o_pin_oe_n[27] |-> !strb_n && o_pin_out[23])
      else $error("bank select low outside upper strobe");
   chk_rw_level: assert property (take && dfn |=> o_pin_out[24+D_RW] == !$past(i_acc_wr))
      else $error("read write line wrong");
   chk_fetch_start: assert property (take && i_acc_fetch && !i_acc_wr && i_acc_ext && dfn |=> !fet_n)
      else $error("fetch marker not low");
   chk_fetch_end: assert property (o_acc_done && dfn |=> fet_n)
      else $error("fetch marker not back high");
   chk_bclk_quarter: assert property ($rose(bclk) && dfn && $past(dfn) |=> s_bclk_turn)
      else $error("bus clock not quarter rate");
   chk_strobe_span: assert property ($fell(strb_n) && dfn && $past(dfn) |-> s_strobe_span)
      else $error("strobe width out of range");
   chk_addr_hold: assert property (!strb_n && $past(!strb_n) && dfn |-> $stable(o_pin_out[28:8]))
      else $error("bus moved during strobe");
   chk_wait_extend: assert property (s_wait_held |=> !strb_n)
      else $error("wait low did not stretch");
endmodule // pio_port_asserts

// [tb_top.sv]
// Purpose: self-checking bench for the port and expansion bus block
// Assumes: i_ce held high; bus clock divide of 4
// Notes: released pins read the memory where it drives, else a fixed background pattern
`timescale 1ns/1ps
module tb_top
   import pio_pkg::*;
;
   // ---------------------------------
   // wiring
   // ---------------------------------
   typedef struct packed {logic [15:0] a; logic w; logic [7:0] d; logic [7:0] e; logic [7:0] o;} pio_row_t;
   localparam logic [31:0] BG = 32'ha5c3_3c96; // level of released pins
   localparam pio_row_t ROWS [11] = '{
      '{16'h1020, 1'b0, 8'h00, 8'h00, 8'hff}, '{16'h1021, 1'b0, 8'h00, 8'h00, 8'hff},
      '{16'h1023, 1'b0, 8'h00, 8'h00, 8'hff}, '{16'h1022, 1'b1, 8'h5a, 8'h00, 8'hff},
      '{16'h1023, 1'b1, 8'hff, 8'h00, 8'h00}, '{16'h1022, 1'b0, 8'h00, 8'h5a, 8'h00},
      '{16'h1023, 1'b1, 8'h00, 8'h00, 8'hff}, '{16'h1022, 1'b0, 8'h00, 8'h96, 8'hff},
      '{16'h1026, 1'b0, 8'h00, 8'h3c, 8'hff}, '{16'h102e, 1'b0, 8'h00, 8'ha5, 8'hff},
      '{16'h2000, 1'b0, 8'h00, 8'h00, 8'hff}};
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   logic mode = 1'b0;
   logic pmd = 1'b0;
   logic req = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic wr = 1'b0;
   logic fetch = 1'b0;
   logic ext = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] wait_cnt = 8'h00;
   logic ready, done, dat_en, wait_n, bank_low;
   logic [7:0] rdata, mdata, q;
   logic [31:0] pin_in, pin_out, oe_n, drv;
   int fails = 0;
   int check_count = 0;
   int lat;
   always #4 i_clk_sys = ~i_clk_sys;
   // a pin reads its driver, else the memory, else the background
   assign drv = {BG[31:27], wait_n, BG[25:8], dat_en ? mdata : BG[7:0]};
   assign pin_in = (~oe_n & pin_out) | (oe_n & drv);
   always @(posedge i_clk_sys) if (!pin_out[27] && !oe_n[27]) bank_low <= 1'b1;
   pio_port uut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(1'b1), .i_mode_select_pin(mode),
      .i_prog_mem_dis(pmd), .i_acc_req(req), .i_acc_addr(addr), .i_acc_wr(wr),
      .i_acc_fetch(fetch), .i_acc_ext(ext), .i_acc_wdata(wdata), .o_acc_ready(ready),
      .o_acc_done(done), .o_acc_rdata(rdata), .i_pin_in(pin_in), .o_pin_out(pin_out),
      .o_pin_oe_n(oe_n));
   pio_ext_mem u_mem (.i_pin(pin_in), .i_wait_cnt(wait_cnt), .o_data(mdata),
      .o_data_en(dat_en), .o_wait_n(wait_n));
   // ---------------------------------
   // tasks
   // ---------------------------------
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask
   // request held until ready is seen, then wait for done
   task automatic acc(input logic [15:0] a, input logic w, f, x, input logic [7:0] d);
      logic r;
      // two idle edges let the pin synchronisers see the last register write
      repeat (2) @(posedge i_clk_sys);
      {req, addr, wr, fetch, ext, wdata} <= {1'b1, a, w, f, x, d};
      do begin
         @(negedge i_clk_sys);
         r = ready;
         @(posedge i_clk_sys);
      end while (r !== 1'b1);
      req <= 1'b0;
      lat = 0;
      do begin
         @(negedge i_clk_sys);
         lat++;
         r = done;
         if (r !== 1'b1) @(posedge i_clk_sys);
      end while (r !== 1'b1 && lat < 200);
      check("access done", 32'h1, {31'h0, r});
      q = rdata;
   endtask
   task automatic summarize();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge i_clk_sys);
      fails++;
      summarize();
   end
   // ---------------------------------
   // sequence
   // ---------------------------------
   initial begin
      repeat (16) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      acc(16'h2000, 1'b0, 1'b0, 1'b0, 8'h00);
      check("single chip oe", 32'hffff_ffff, oe_n);
      foreach (ROWS[i]) begin
         acc(ROWS[i].a, ROWS[i].w, 1'b0, 1'b0, ROWS[i].d);
         check("reg read", {ROWS[i].e, ROWS[i].o, 16'd1}, {q, oe_n[7:0], 16'(lat)});
      end
      @(posedge i_clk_sys);
      {i_rstn, mode} <= 2'b01;
      repeat (16) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      acc(16'h1020, 1'b0, 1'b0, 1'b0, 8'h00);
      check("bus mode", 32'h00ff_0000, {q, oe_n[23:8]});
      acc(16'h102c, 1'b1, 1'b0, 1'b0, 8'hff);
      acc(16'h8012, 1'b1, 1'b0, 1'b1, 8'hc7);
      check("write slow", 32'h1, 32'(lat >= 5));
      bank_low = 1'b0;
      acc(16'h8012, 1'b0, 1'b1, 1'b1, 8'h00);
      check("upper read", {8'hc7, 8'h01}, {q, 7'h00, bank_low});
      wait_cnt = 8'h03;
      acc(16'h0013, 1'b0, 1'b0, 1'b1, 8'h00);
      wait_cnt = 8'h00;
      check("wait read", {8'h49, 8'h01}, {q, 8'(lat >= 12)});
      pmd <= 1'b1;
      acc(16'h1022, 1'b0, 1'b0, 1'b0, 8'h00);
      pmd <= 1'b0;
      check("frame external", {8'h78, 8'h01}, {q, 8'(lat >= 5)});
      acc(16'h102c, 1'b1, 1'b0, 1'b0, 8'hf7);
      acc(16'h102e, 1'b1, 1'b0, 1'b0, 8'h08);
      acc(16'h102f, 1'b1, 1'b0, 1'b0, 8'h08);
      bank_low = 1'b0;
      acc(16'h8040, 1'b0, 1'b0, 1'b1, 8'h00);
      check("bank disabled", 32'h1, {bank_low, oe_n[27], pin_out[27]});
      summarize();
   end
endmodule // tb_top
bind pio_port pio_port_asserts #(.CLK_DIV(CLK_DIV)) u_chk (.i_clk_sys(i_clk_sys),
   .i_rstn(i_rstn), .i_ce(i_ce), .i_prog_mem_dis(i_prog_mem_dis), .i_acc_req(i_acc_req),
   .i_acc_wr(i_acc_wr), .i_acc_fetch(i_acc_fetch), .i_acc_ext(i_acc_ext),
   .o_acc_ready(o_acc_ready), .o_acc_done(o_acc_done), .i_pin_in(i_pin_in),
   .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n));
